// ---- fpbl_chipset_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Chipset power state model
// ----------------------------------------
module fpbl_chipset_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       supply_i,     // Supply enable from block
  input  wire logic       power_req_i,  // Power request from block
  input  wire logic       serve_i,      // Host services off requests
  input  wire logic [1:0] want_i,       // Host sleep state while running
  output logic      [1:0] sleep_o       // Reported sleep state
);
  logic running;  // Request seen after power-up means off
  logic shut;     // Off request serviced
  // Power-up request must not be taken for an off request
  always_ff @(posedge clk_i) begin
    if (reset_i || !supply_i) begin
      running <= 1'b0;
      shut    <= 1'b0;
    end else begin
      if (!power_req_i) running <= 1'b1;
      if (power_req_i && running && serve_i) shut <= 1'b1;
    end
  end
  assign sleep_o = shut ? fpbl_pkg::SLP_S5 : want_i;
endmodule : fpbl_chipset_model

// ---- fpbl_debounce.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Synchroniser and debouncer for one active-low button
// ----------------------------------------
module fpbl_debounce #(
  parameter int unsigned SETTLE_CYC = fpbl_pkg::DEBOUNCE_CYC  // Stable time before accept
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic button_n_i,   // Raw pin, active low
  output logic      press_o       // One-cycle pulse on accepted press
);

  localparam int W = $clog2(SETTLE_CYC + 1);

  typedef struct packed {
    logic         sync1;   // First synchroniser stage, read only by sync2
    logic         sync2;   // Second stage
    logic         stable;  // Debounced level, high = pressed
    logic [W-1:0] count;   // Settle counter
    logic         press;   // Edge pulse
  } fpbl_db_t;

  fpbl_db_t st, next_st;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st       = st;
    next_st.sync1 = ~button_n_i;
    next_st.sync2 = st.sync1;
    next_st.press = 1'b0;
    if (st.sync2 == st.stable) begin
      next_st.count = '0;                          // Agrees, nothing pending
    end else if (st.count == W'(SETTLE_CYC - 1)) begin
      next_st.count  = '0;
      next_st.stable = st.sync2;
      next_st.press  = st.sync2;                   // Press edge only, see RULE11
    end else begin
      next_st.count = st.count + 1'b1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign press_o = st.press;

endmodule : fpbl_debounce

// ---- fpbl_front_panel.sv ----
`timescale 1ns/1ps
// How it works
// RULE1: Power button or wake edge starts power-up
// RULE2: Button only requests chipset, never switches supply (a press in FPBL_OFF switches supply on directly)
// RULE3: Drop supply enable when chipset reports off
// RULE4: Unserviced off request forces off after timeout
// RULE5: Reset button forwarded to chipset, unconditionally
// RULE6: Identify button toggles identify lamp
// RULE7: Identify lamp holds until button or command
// RULE8: Power lamp lit while DC power on
// RULE9: Power lamp off S5, blink S1, solid S0
// RULE10: Identify solid by button, blinking by command (a command state other than ID_CMD_ON or ID_CMD_OFF lights it solid)
// RULE11: Buttons synchronised, debounced, act once per press
// RULE12: Blink rate from divider, equal halves
module fpbl_front_panel #(
  parameter int unsigned OFF_TIMEOUT = fpbl_pkg::OFF_TIMEOUT_CYC,  // Forced off delay
  parameter int unsigned BLINK_HALF  = fpbl_pkg::BLINK_HALF_CYC,   // Blink half period
  parameter int unsigned SETTLE      = fpbl_pkg::DEBOUNCE_CYC,     // Debounce settle
  parameter int unsigned REQ_PULSE   = fpbl_pkg::REQ_PULSE_CYC     // Request pulse width
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       front_power_button_n_i,    // Power button, active low
  input  wire logic       front_reset_button_n_i,    // Reset button, active low
  input  wire logic       front_identify_button_n_i, // Identify button, active low
  input  wire logic       chipset_wake_i,            // Chipset wake event level
  input  wire logic [1:0] chipset_sleep_state_i,     // Chipset sleep state
  input  wire logic       identify_cmd_valid_i,      // Management identify command strobe
  input  wire logic [1:0] identify_cmd_state_i,      // Commanded identify state
  output logic            supply_enable_out_o,       // Power supply enable
  output logic            power_good_o,              // Power good to system
  output logic            system_reset_n_o,          // System reset, active low
  output logic            chipset_power_req_o,       // Power button request to chipset
  output logic            chipset_reset_req_o,       // Reset request to chipset
  output logic            front_power_lamp_n_o,      // Power lamp, active low
  output logic            front_identify_lamp_n_o    // Identify lamp, active low
);

  localparam int TW = $clog2(OFF_TIMEOUT + 1);
  localparam int BW = $clog2(BLINK_HALF + 1);
  localparam int PW = $clog2(REQ_PULSE + 1);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic               wake_s1;      // Wake synchroniser first stage
    logic               wake_s2;      // Wake synchroniser second stage
    logic               wake_d;       // Previous wake for edge
    logic [1:0]         slp_s1;       // Sleep state sync first stage
    logic [1:0]         slp_s2;       // Sleep state sync second stage
    fpbl_pkg::fpbl_pwr_t pwr;         // Power sequencer
    logic [TW-1:0]      off_cnt;      // Forced-off timer
    logic [BW-1:0]      blink_cnt;    // Blink divider
    logic               blink;        // Blink phase
    logic [PW-1:0]      preq_cnt;     // Power request pulse timer
    logic [PW-1:0]      rreq_cnt;     // Reset request pulse timer
    logic               id_on;        // Identify active
    logic               id_by_cmd;    // Identify set by command
    logic               supply_en;
    logic               pgood;
    logic               rst_n;
    logic               preq;
    logic               rreq;
    logic               pwr_lamp_n;
    logic               id_lamp_n;
  } fpbl_st_t;

  fpbl_st_t st, next_st;

  logic pwr_press;  // Debounced power press pulse
  logic rst_press;  // Debounced reset press pulse
  logic id_press;   // Debounced identify press pulse

  // ----------------------------------------
  // Button conditioning
  // ----------------------------------------
  fpbl_debounce #(.SETTLE_CYC(SETTLE)) u_db_pwr (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .button_n_i (front_power_button_n_i),
    .press_o    (pwr_press)
  );  // see RULE11

  fpbl_debounce #(.SETTLE_CYC(SETTLE)) u_db_rst (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .button_n_i (front_reset_button_n_i),
    .press_o    (rst_press)
  );

  fpbl_debounce #(.SETTLE_CYC(SETTLE)) u_db_id (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .button_n_i (front_identify_button_n_i),
    .press_o    (id_press)
  );

  // Pulse counter reload helper
  function automatic logic [PW-1:0] pulse_next(input logic start, input logic [PW-1:0] cnt);
    if (start) begin
      pulse_next = PW'(REQ_PULSE);
    end else if (cnt != '0) begin
      pulse_next = cnt - 1'b1;
    end else begin
      pulse_next = '0;
    end
  endfunction : pulse_next

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic wake_edge;
    logic slp_off;
    wake_edge = 1'b0;
    slp_off   = 1'b0;
    next_st   = st;

    // Two-flop synchronisers for chipset levels
    next_st.wake_s1 = chipset_wake_i;
    next_st.wake_s2 = st.wake_s1;
    next_st.wake_d  = st.wake_s2;
    next_st.slp_s1  = chipset_sleep_state_i;
    next_st.slp_s2  = st.slp_s1;
    wake_edge       = st.wake_s2 & ~st.wake_d;
    slp_off         = (st.slp_s2 == fpbl_pkg::SLP_S5);

    // Blink divider, equal on and off halves
    if (st.blink_cnt == BW'(BLINK_HALF - 1)) begin
      next_st.blink_cnt = '0;
      next_st.blink     = ~st.blink;                        // see RULE12
    end else begin
      next_st.blink_cnt = st.blink_cnt + 1'b1;
    end

    // Power button always becomes a chipset request; in FPBL_OFF it also switches supply on
    next_st.preq_cnt = pulse_next(pwr_press, st.preq_cnt);  // see RULE2
    // Reset request path has no firmware gate
    next_st.rreq_cnt = pulse_next(rst_press, st.rreq_cnt);  // see RULE5

    // Power sequencer
    unique case (st.pwr)
      fpbl_pkg::FPBL_OFF: begin
        if (pwr_press || wake_edge) begin
          next_st.pwr = fpbl_pkg::FPBL_ON;                  // see RULE1
        end
      end
      fpbl_pkg::FPBL_ON: begin
        if (pwr_press) begin
          next_st.pwr     = fpbl_pkg::FPBL_OFF_PEND;
          next_st.off_cnt = '0;
        end else if (slp_off) begin
          next_st.pwr = fpbl_pkg::FPBL_OFF;                 // see RULE3
        end
      end
      fpbl_pkg::FPBL_OFF_PEND: begin
        next_st.off_cnt = st.off_cnt + 1'b1;
        if (slp_off) begin
          next_st.pwr = fpbl_pkg::FPBL_OFF;                 // see RULE3
        end else if (st.off_cnt == TW'(OFF_TIMEOUT - 1)) begin
          next_st.pwr = fpbl_pkg::FPBL_OFF;                 // see RULE4
        end
      end
      default: begin
        next_st.pwr = fpbl_pkg::FPBL_OFF;                   // Illegal code recovers to off
      end
    endcase

    // Supply, power good and reset follow the sequencer
    next_st.supply_en = (next_st.pwr != fpbl_pkg::FPBL_OFF);  // see RULE1
    next_st.pgood     = st.supply_en && next_st.supply_en;   // Good one cycle after enable
    next_st.rst_n     = st.pgood && next_st.pgood;           // Reset released after good
    next_st.preq      = (next_st.preq_cnt != '0);
    next_st.rreq      = (next_st.rreq_cnt != '0);

    // Identify: command and button; command wins if simultaneous
    if (identify_cmd_valid_i) begin
      next_st.id_on     = (identify_cmd_state_i != fpbl_pkg::ID_CMD_OFF);  // see RULE7
      next_st.id_by_cmd = (identify_cmd_state_i == fpbl_pkg::ID_CMD_ON);
    end else if (id_press) begin
      next_st.id_on     = ~st.id_on;                        // see RULE6
      next_st.id_by_cmd = 1'b0;
    end

    // Identify lamp: solid by button or by a command other than ID_CMD_ON or ID_CMD_OFF, blinking by ID_CMD_ON command
    next_st.id_lamp_n = ~(next_st.id_on && (!next_st.id_by_cmd || st.blink));  // see RULE10

    // Power lamp from DC power and sleep state
    if (!next_st.supply_en || slp_off) begin
      next_st.pwr_lamp_n = 1'b1;                            // see RULE9
    end else if (st.slp_s2 == fpbl_pkg::SLP_S1) begin
      next_st.pwr_lamp_n = ~st.blink;                       // see RULE9
    end else begin
      next_st.pwr_lamp_n = 1'b0;                            // see RULE8
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st            <= '0;
      st.pwr        <= fpbl_pkg::FPBL_OFF;
      st.pwr_lamp_n <= 1'b1;
      st.id_lamp_n  <= 1'b1;
      st.slp_s1     <= fpbl_pkg::SLP_S5;
      st.slp_s2     <= fpbl_pkg::SLP_S5;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------
  assign supply_enable_out_o     = st.supply_en;
  assign power_good_o            = st.pgood;
  assign system_reset_n_o        = st.rst_n;
  assign chipset_power_req_o     = st.preq;
  assign chipset_reset_req_o     = st.rreq;
  assign front_power_lamp_n_o    = st.pwr_lamp_n;
  assign front_identify_lamp_n_o = st.id_lamp_n;

endmodule : fpbl_front_panel

// ---- fpbl_pkg.sv ----
package fpbl_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ           = 10_000_000;  // Standby clock rate
  localparam int unsigned OFF_TIMEOUT_MS   = 4500;        // Forced off, inside 4 to 5 s
  localparam int unsigned OFF_TIMEOUT_CYC  = (CLK_HZ / 1000) * OFF_TIMEOUT_MS;
  localparam int unsigned BLINK_HZ         = 1;           // About 1 Hz blink
  localparam int unsigned BLINK_HALF_CYC   = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned DEBOUNCE_US      = 10000;       // Button settle time
  localparam int unsigned DEBOUNCE_CYC     = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
  localparam int unsigned REQ_PULSE_US     = 16;          // Request pulse to chipset
  localparam int unsigned REQ_PULSE_CYC    = (CLK_HZ / 1_000_000) * REQ_PULSE_US;

  // ----------------------------------------
  // Chipset sleep state encoding
  // ----------------------------------------
  localparam logic [1:0] SLP_S0 = 2'h0;  // Working
  localparam logic [1:0] SLP_S1 = 2'h1;  // Light sleep
  localparam logic [1:0] SLP_S5 = 2'h3;  // Soft off

  // ----------------------------------------
  // Identify source
  // ----------------------------------------
  localparam logic [1:0] ID_CMD_OFF   = 2'h0;  // Command: lamp off
  localparam logic [1:0] ID_CMD_ON    = 2'h1;  // Command: identify by command

  // Power sequencer states
  typedef enum logic [1:0] {
    FPBL_OFF,
    FPBL_ON,
    FPBL_OFF_PEND
  } fpbl_pwr_t;

endpackage : fpbl_pkg

// ---- fpbl_properties.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the front panel block
// ----------------------------------------
module fpbl_checker #(
  parameter int unsigned OFF_TIMEOUT = 20  // Forced off delay
) (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       front_power_button_n_i,
  input wire logic       front_reset_button_n_i,
  input wire logic       front_identify_button_n_i,
  input wire logic       chipset_wake_i,
  input wire logic [1:0] chipset_sleep_state_i,
  input wire logic       identify_cmd_valid_i,
  input wire logic [1:0] identify_cmd_state_i,
  input wire logic       supply_enable_out_o,
  input wire logic       power_good_o,
  input wire logic       system_reset_n_o,
  input wire logic       chipset_power_req_o,
  input wire logic       chipset_reset_req_o,
  input wire logic       front_power_lamp_n_o,
  input wire logic       front_identify_lamp_n_o
);
  localparam int TO_MAX = OFF_TIMEOUT + 4;  // Slack for sync and request stages
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Power good, then reset release, one cycle apart
  sequence power_up_s;
    ##1 power_good_o ##1 system_reset_n_o;
  endsequence
  // Request issued while already running is an off request
  sequence off_req_s;
    $rose(chipset_power_req_o) && $past(supply_enable_out_o);
  endsequence
  req_pulse_a: assert property ($rose(chipset_power_req_o) |->
    chipset_power_req_o[*2] ##1 !chipset_power_req_o) else $error("power request width");
  reset_pulse_a: assert property ($rose(chipset_reset_req_o) |->
    chipset_reset_req_o[*2] ##1 !chipset_reset_req_o) else $error("reset request width");
  power_up_a: assert property ($rose(supply_enable_out_o) |-> power_up_s)
    else $error("power-up order");
  good_needs_supply_a: assert property (power_good_o |-> $past(supply_enable_out_o))
    else $error("power good without supply");
  soft_off_drop_a: assert property (supply_enable_out_o &&
    chipset_sleep_state_i == fpbl_pkg::SLP_S5 |-> ##[1:4] !supply_enable_out_o)
    else $error("supply kept in soft off");
  forced_off_a: assert property (off_req_s |-> ##[1:TO_MAX] !supply_enable_out_o)
    else $error("no forced off");
  lamp_dark_a: assert property ((!supply_enable_out_o)[*2] |-> front_power_lamp_n_o)
    else $error("power lamp lit while off");
  lamp_solid_a: assert property ((supply_enable_out_o &&
    chipset_sleep_state_i == fpbl_pkg::SLP_S0)[*4] |-> !front_power_lamp_n_o)
    else $error("power lamp dark in S0");
  id_cmd_off_a: assert property (identify_cmd_valid_i &&
    identify_cmd_state_i == fpbl_pkg::ID_CMD_OFF |-> ##2 front_identify_lamp_n_o)
    else $error("identify lamp kept on");
  id_cmd_solid_a: assert property (identify_cmd_valid_i &&
    identify_cmd_state_i == 2'h2 |-> ##2 (!front_identify_lamp_n_o)[*4])
    else $error("identify lamp not solid");
endmodule : fpbl_checker

bind fpbl_front_panel fpbl_checker #(.OFF_TIMEOUT(OFF_TIMEOUT)) chk_u (
  .clk_i(clk_i), .reset_i(reset_i), .front_power_button_n_i(front_power_button_n_i),
  .front_reset_button_n_i(front_reset_button_n_i), .chipset_wake_i(chipset_wake_i),
  .front_identify_button_n_i(front_identify_button_n_i),
  .chipset_sleep_state_i(chipset_sleep_state_i), .identify_cmd_valid_i(identify_cmd_valid_i),
  .identify_cmd_state_i(identify_cmd_state_i), .supply_enable_out_o(supply_enable_out_o),
  .power_good_o(power_good_o), .system_reset_n_o(system_reset_n_o),
  .chipset_power_req_o(chipset_power_req_o), .chipset_reset_req_o(chipset_reset_req_o),
  .front_power_lamp_n_o(front_power_lamp_n_o),
  .front_identify_lamp_n_o(front_identify_lamp_n_o));

// ---- tb.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Front panel block bench
// ----------------------------------------
module tb;
  localparam int TO = 20;  // Shortened forced off delay
  logic       clk_i = 1'b0, reset_i = 1'b1, pwr_n = 1'b1, rst_n = 1'b1, id_n = 1'b1;
  logic       wake = 1'b0, serve = 1'b1, cmd_v = 1'b0;
  logic [1:0] cmd_s = 2'h0, want = 2'h0, sleep;
  logic       sup, pg, srst_n, preq, rreq, plamp_n, ilamp_n;
  int         failures = 0, samples_checked = 0, cyc = 0, hi, ch, n;
  fpbl_front_panel #(.OFF_TIMEOUT(TO), .BLINK_HALF(4), .SETTLE(3), .REQ_PULSE(2)) dut_u (
    .clk_i(clk_i), .reset_i(reset_i), .front_power_button_n_i(pwr_n),
    .front_reset_button_n_i(rst_n), .front_identify_button_n_i(id_n), .chipset_wake_i(wake),
    .chipset_sleep_state_i(sleep), .identify_cmd_valid_i(cmd_v), .identify_cmd_state_i(cmd_s),
    .supply_enable_out_o(sup), .power_good_o(pg), .system_reset_n_o(srst_n),
    .chipset_power_req_o(preq), .chipset_reset_req_o(rreq),
    .front_power_lamp_n_o(plamp_n), .front_identify_lamp_n_o(ilamp_n));
  fpbl_chipset_model part_u (.clk_i(clk_i), .reset_i(reset_i), .supply_i(sup),
    .power_req_i(preq), .serve_i(serve), .want_i(want), .sleep_o(sleep));
  initial forever #50 clk_i = ~clk_i;
  // Hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      finish_test();
    end
  end
  function automatic logic pick(input int k);
    case (k)
      0: return sup;
      1: return preq;
      2: return rreq;
      3: return plamp_n;
      default: return ilamp_n;
    endcase
  endfunction : pick
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // Hold one button low for a number of cycles
  task automatic press(input int b, input int low);
    @(posedge clk_i);
    if (b == 0) pwr_n <= 1'b0;
    else if (b == 1) rst_n <= 1'b0;
    else id_n <= 1'b0;
    repeat (low) @(posedge clk_i);
    pwr_n <= 1'b1;
    rst_n <= 1'b1;
    id_n <= 1'b1;
  endtask : press
  // High cycles and changes of one output
  task automatic watch(input int k, input int len, output int h, output int c);
    logic last;
    h = 0;
    c = 0;
    last = pick(k);
    repeat (len) begin
      @(negedge clk_i);
      h += int'(pick(k));
      c += int'(pick(k) != last);
      last = pick(k);
    end
  endtask : watch
  task automatic send_cmd(input logic [1:0] s);
    @(posedge clk_i);
    cmd_v <= 1'b1;
    cmd_s <= s;
    @(posedge clk_i);
    cmd_v <= 1'b0;
  endtask : send_cmd
  // Bounce refused, full press powers up
  task automatic t_power_on;
    fork press(0, 1); watch(1, 14, hi, ch); join
    chk("bounce", 8'(hi), 8'h00);
    fork press(0, 10); watch(1, 30, hi, ch); join
    chk("pwr req", 8'(hi), 8'h02);
    chk("supply", 8'({sup, pg, srst_n, plamp_n}), 8'h0E);
  endtask : t_power_on
  task automatic t_reset;
    fork press(1, 10); watch(2, 30, hi, ch); join
    chk("rst req", {7'(hi), sup}, 8'h05);
  endtask : t_reset
  // S1 blink period and halves, then solid in S0
  task automatic t_blink;
    @(posedge clk_i);
    want <= fpbl_pkg::SLP_S1;
    watch(3, 12, hi, ch);
    while (ch == 0) watch(3, 1, hi, ch);
    watch(3, 32, hi, ch);
    // Four whole blink periods: half the samples dark, eight changes
    chk("blink high", 8'(hi), 8'h10);
    chk("blink edges", 8'(ch), 8'h08);
    @(posedge clk_i);
    want <= fpbl_pkg::SLP_S0;
    repeat (6) @(negedge clk_i);
    chk("solid", 8'(plamp_n), 8'h00);
  endtask : t_blink
  // Button toggles, commands override
  task automatic t_identify;
    logic [7:0] exp_hi [4] = '{8'h08, 8'h00, 8'h00, 8'h10};
    fork press(2, 10); watch(4, 30, hi, ch); join
    chk("id on", {7'(ch), ilamp_n}, 8'h02);
    fork press(2, 10); watch(4, 30, hi, ch); join
    chk("id off", 8'(ilamp_n), 8'h01);
    press(2, 10);
    repeat (20) @(negedge clk_i);
    for (int i = 0; i < 4; i++) begin
      send_cmd(2'(i == 3 ? 0 : i + 1));
      repeat (4) @(negedge clk_i);
      watch(4, 16, hi, ch);
      chk("id cmd", 8'(hi), exp_hi[i]);
    end
  endtask : t_identify
  task automatic t_off_served;
    fork press(0, 10); watch(0, 30, hi, ch); join
    chk("off", {4'h0, sup, pg, plamp_n, ch == 1}, 8'h03);
  endtask : t_off_served
  task automatic t_wake;
    @(posedge clk_i);
    wake <= 1'b1;
    repeat (3) @(posedge clk_i);
    wake <= 1'b0;
    repeat (8) @(negedge clk_i);
    chk("wake", 8'(sup), 8'h01);
  endtask : t_wake
  // Host ignores the off request
  task automatic t_timeout;
    @(posedge clk_i);
    serve <= 1'b0;
    fork
      press(0, 10);
      begin
        while (preq !== 1'b1) @(negedge clk_i);
        n = 0;
        while (sup === 1'b1) begin
          @(negedge clk_i);
          n++;
        end
      end
    join
    chk("timeout", 8'(n >= TO && n <= TO + 2), 8'h01);
  endtask : t_timeout
  task automatic finish_test;
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    // Everything dark and idle straight out of reset
    @(negedge clk_i);
    chk("reset", {1'h0, sup, pg, srst_n, preq, rreq, plamp_n, ilamp_n}, 8'h03);
    t_power_on();
    t_reset();
    t_blink();
    t_identify();
    t_off_served();
    t_wake();
    t_timeout();
    finish_test();
  end
endmodule : tb
